// ==== verilog/gxp_defs.vh ====
// gxp_defs.vh: constants for the serial gpio expander core
// assumes: included by the core and by the bench, no other users
`ifndef GXP_DEFS_VH
`define GXP_DEFS_VH
// register pointer codes
`define GXP_IN0   4'h0
`define GXP_IN1   4'h1
`define GXP_INV0  4'h2
`define GXP_INV1  4'h3
`define GXP_HOLD0 4'h4
`define GXP_HOLD1 4'h5
`define GXP_PULL0 4'h6
`define GXP_PULL1 4'h7
`define GXP_DIR0  4'h8
`define GXP_DIR1  4'h9
`define GXP_OUTPUT_VALUE_BANK0  4'hA
`define GXP_OUTPUT_VALUE_BANK1  4'hB
`define GXP_IRQ_MASK_BANK0  4'hC
`define GXP_IRQ_MASK_BANK1  4'hD
`define GXP_FLG0  4'hE
`define GXP_FLG1  4'hF
// command byte fields
`define GXP_CMD_AI   7
`define GXP_CMD_RSVH 6
`define GXP_CMD_RSVL 4
// hold enable fields
`define GXP_HOLD_KEEP 0
`define GXP_HOLD_PULL 1
// reset values
`define GXP_CMD_RST  8'h00
`define GXP_INV_RST  8'h00
`define GXP_HOLD_RST 8'h00
`define GXP_PULL_RST 8'h00
`define GXP_DIR_RST  8'hFF
`define GXP_OUT_RST  8'h00
`define GXP_MSK_RST  8'hFF
// slave address, arbitrary values
`define GXP_FIXED_ADDR 7'h20
`define GXP_ADDR_HI    3'h2
`endif

// ==== verilog/gxp_core.v ====
// gxp_core.v: two-bank sixteen pin gpio expander behind a serial slave
// assumes: scl, sda, pins and address selects are asynchronous to clk
// Operation
// - sixteen pins in two banks of eight, each with own registers
// - direction register bit selects input or output per pin
// - input register read value optionally inverted per pin
// - per bank either keeper or pulls; pulls only when keeper off
// - keeper holds last level, external drivers may override
// - address byte lsb one means read, zero means write
// - small variant answers one fixed slave address
// - after write address ack, next byte goes to command pointer
// - low four pointer bits select one of sixteen registers
// - command acked only if a defined code, otherwise not acked
// - command pointer resets to zero, auto step cleared
// - auto step set advances pointer after each data byte
// - pointer wraps from last register to register zero
// - auto step clear keeps pointer on the same register
// - codes map in bank pairs from inputs up to interrupt flags
// - input and flag registers read only, others read write
// - each register written alone, others untouched
// - active low reset returns device to initial state
// - interrupt is open drain, pulled low when asserted
// - unmasked input change raises interrupt, all masked by default
// - reset makes all pins inputs and restores defaults
// - input registers show pin levels, writes acked and ignored
// - inversion bit one inverts the read bit, zero leaves it
`timescale 1ns/1ns
`include "gxp_defs.vh"
module gxp_core #(
  parameter       WIDE_PKG   = 0,
  parameter [6:0] FIXED_ADDR = `GXP_FIXED_ADDR,
  parameter [2:0] ADDR_HI    = `GXP_ADDR_HI
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe,
  input  wire [3:0]  addr_sel_i,
  input  wire [15:0] gpio_i,
  output reg  [15:0] gpio_o,
  output reg  [15:0] gpio_oe,
  output reg  [15:0] keep_en,
  output reg  [15:0] pull_en,
  output reg  [15:0] pull_up,
  output reg         int_o,
  output reg         int_oe
);
  // link states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_CMD  = 3'd2;
  localparam [2:0] ST_WDAT = 3'd3;
  localparam [2:0] ST_ACK  = 3'd4;
  localparam [2:0] ST_RDAT = 3'd5;
  localparam [2:0] ST_MACK = 3'd6;

  // synchroniser stages, link state and register storage
  reg  [2:0]  scl_sq;
  reg  [2:0]  sda_sq;
  reg  [3:0]  asel_s1_q;
  reg  [3:0]  asel_q;
  reg  [15:0] pin_s1_q;
  reg  [15:0] pin_q;
  reg  [15:0] pin_prev_q;
  reg  [2:0]  st_q;
  reg  [2:0]  nxt_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  sr_q;
  reg  [7:0]  tx_q;
  reg  [3:0]  ptr_q;
  reg         ai_q;
  reg  [7:0]  rf_q [0:15];
  reg  [15:0] flag_q;
  reg  [15:0] flag_clr;
  reg  [6:0]  my_addr;
  integer     i;
  // reset image of the command byte, split into pointer and auto step
  localparam [7:0] CMD_RST = `GXP_CMD_RST;

  // edges seen on the synchronised link lines
  wire scl_rise = scl_sq[1] & ~scl_sq[2];
  wire scl_fall = ~scl_sq[1] & scl_sq[2];
  wire sda_bit  = sda_sq[1];
  // start and stop only while scl stays high
  wire start_ev = scl_sq[1] & scl_sq[2] & ~sda_sq[1] & sda_sq[2];
  wire stop_ev  = scl_sq[1] & scl_sq[2] & sda_sq[1] & ~sda_sq[2];

  // pointer after one data byte; the carry out wraps 0Fh to 00h
  function [3:0] ptr_next;
    input [3:0] cur;
    input       step;
    begin
      if (step)
        ptr_next = cur + 4'h1;
      else
        ptr_next = cur;
    end
  endfunction

  // a load from a flag register clears that bank's flags
  function [15:0] clr_mask;
    input [3:0] idx;
    begin
      case (idx)
        `GXP_FLG0: clr_mask = 16'h00FF;
        `GXP_FLG1: clr_mask = 16'hFF00;
        default:   clr_mask = 16'h0000;
      endcase
    end
  endfunction

  // first bit out on the wire
  function msb_of;
    input [7:0] b;
    begin
      msb_of = b[7];
    end
  endfunction

  // pulls only when the keeper is off
  function pull_on;
    input [7:0] hold;
    begin
      pull_on = hold[`GXP_HOLD_PULL] & ~hold[`GXP_HOLD_KEEP];
    end
  endfunction

  // reset value of each storage slot
  function [7:0] rst_val;
    input [3:0] idx;
    begin
      case (idx[3:1])
        3'd1:    rst_val = `GXP_INV_RST;
        3'd2:    rst_val = `GXP_HOLD_RST;
        3'd3:    rst_val = `GXP_PULL_RST;
        3'd4:    rst_val = `GXP_DIR_RST;
        3'd5:    rst_val = `GXP_OUT_RST;
        3'd6:    rst_val = `GXP_MSK_RST;
        default: rst_val = 8'h00;
      endcase
    end
  endfunction

  // read only slots never take a write
  function is_ro;
    input [3:0] idx;
    begin
      is_ro = (idx == `GXP_IN0) | (idx == `GXP_IN1) |
              (idx == `GXP_FLG0) | (idx == `GXP_FLG1);
    end
  endfunction

  // read mux over the sixteen codes
  function [7:0] rd_byte;
    input [3:0] idx;
    begin
      case (idx)
        `GXP_IN0: rd_byte = pin_q[7:0] ^ rf_q[`GXP_INV0];
        `GXP_IN1: rd_byte = pin_q[15:8] ^ rf_q[`GXP_INV1];
        `GXP_FLG0: rd_byte = flag_q[7:0];
        `GXP_FLG1: rd_byte = flag_q[15:8];
        default: rd_byte = rf_q[idx];
      endcase
    end
  endfunction

  // slave address, fixed or from select pins
  always @* begin
    if (WIDE_PKG != 0)
      my_addr = {ADDR_HI, asel_q};
    else
      my_addr = FIXED_ADDR;
  end

  // link line synchronisers; third stage is edge history only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sq <= 3'h7;
      sda_sq <= 3'h7;
    end else begin
      scl_sq <= {scl_sq[1:0], scl_i};
      sda_sq <= {sda_sq[1:0], sda_i};
    end
  end

  // address select synchroniser, two stages
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asel_s1_q <= 4'h0;
      asel_q    <= 4'h0;
    end else begin
      asel_s1_q <= addr_sel_i;
      asel_q    <= asel_s1_q;
    end
  end

  // pin level synchroniser; pins may move at any time
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 16'h0000;
      pin_q    <= 16'h0000;
    end else begin
      pin_s1_q <= gpio_i;
      pin_q    <= pin_s1_q;
    end
  end

  // slave protocol engine
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= ST_IDLE;
      nxt_q    <= ST_IDLE;
      cnt_q    <= 4'h0;
      sr_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= CMD_RST[3:0];
      ai_q     <= CMD_RST[`GXP_CMD_AI];
      sda_oe   <= 1'b0;
      flag_clr <= 16'h0000;
      for (i = 0; i < 16; i = i + 1)
        rf_q[i] <= rst_val(i[3:0]);
    end else begin
      flag_clr <= 16'h0000;
      if (start_ev) begin
        // repeated start also lands here
        st_q   <= ST_ADDR;
        cnt_q  <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_ev) begin
        st_q   <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_q)
          // shift in address, command or data, msb first
          ST_ADDR, ST_CMD, ST_WDAT: begin
            if (scl_rise) begin
              sr_q  <= {sr_q[6:0], sda_bit};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                if (sr_q[7:1] == my_addr) begin
                  sda_oe <= 1'b1;
                  st_q   <= ST_ACK;
                  // lsb one reads, zero writes
                  nxt_q  <= sr_q[0] ? ST_RDAT : ST_CMD;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else if (st_q == ST_CMD) begin
                // reserved high bits refuse the code
                if (sr_q[`GXP_CMD_RSVH:`GXP_CMD_RSVL] == 3'h0) begin
                  sda_oe <= 1'b1;
                  ptr_q  <= sr_q[3:0];
                  ai_q   <= sr_q[`GXP_CMD_AI];
                  st_q   <= ST_ACK;
                  nxt_q  <= ST_WDAT;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                // data byte: always acked, read only ignored
                sda_oe <= 1'b1;
                st_q   <= ST_ACK;
                nxt_q  <= ST_WDAT;
                if (!is_ro(ptr_q))
                  rf_q[ptr_q] <= sr_q;
                ptr_q <= ptr_next(ptr_q, ai_q);
              end // pointer untouched when auto step clear
            end
          end
          // ninth slot: own ack, then data or read hand-over
          ST_ACK: begin
            if (scl_fall) begin
              st_q <= nxt_q;
              if (nxt_q == ST_RDAT) begin
                tx_q     <= rd_byte(ptr_q);
                sda_oe   <= ~msb_of(rd_byte(ptr_q));
                flag_clr <= clr_mask(ptr_q);
                ptr_q    <= ptr_next(ptr_q, ai_q);
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          // read byte, one bit per falling edge
          ST_RDAT: begin
            if (scl_fall) begin
              if (cnt_q == 4'h7) begin
                cnt_q  <= 4'h0;
                sda_oe <= 1'b0;
                st_q   <= ST_MACK;
              end else begin
                cnt_q  <= cnt_q + 4'h1;
                tx_q   <= {tx_q[6:0], 1'b0};
                sda_oe <= ~tx_q[6];
              end
            end
          end
          ST_MACK: begin
            // master nack ends the read; ack asks for more
            if (scl_rise) begin
              st_q  <= sda_bit ? ST_IDLE : ST_ACK;
              nxt_q <= ST_RDAT;
            end
          end
          // unknown code falls back to idle
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // previous pin levels for change detect
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      pin_prev_q <= 16'h0000;
    else
      pin_prev_q <= pin_q;
  end

  // sticky flags; a new change beats a read clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      flag_q <= 16'h0000;
    else
      flag_q <= (flag_q & ~flag_clr) |
                ((pin_q ^ pin_prev_q) &
                 ~{rf_q[`GXP_IRQ_MASK_BANK1], rf_q[`GXP_IRQ_MASK_BANK0]});
  end

  // pin drivers follow direction and output registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpio_o  <= 16'h0000;
      gpio_oe <= 16'h0000;
    end else begin
      gpio_o  <= {rf_q[`GXP_OUTPUT_VALUE_BANK1], rf_q[`GXP_OUTPUT_VALUE_BANK0]};
      // direction bit one means input
      gpio_oe <= ~{rf_q[`GXP_DIR1], rf_q[`GXP_DIR0]};
    end
  end

  // keeper and pulls per bank; analog parts sit outside the core
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      keep_en <= 16'h0000;
      pull_en <= 16'h0000;
      pull_up <= 16'h0000;
    end else begin
      keep_en <= {{8{rf_q[`GXP_HOLD1][`GXP_HOLD_KEEP]}},
                  {8{rf_q[`GXP_HOLD0][`GXP_HOLD_KEEP]}}};
      pull_en <= {{8{pull_on(rf_q[`GXP_HOLD1])}},
                  {8{pull_on(rf_q[`GXP_HOLD0])}}};
      pull_up <= {rf_q[`GXP_PULL1], rf_q[`GXP_PULL0]};
    end
  end

  // open drain pads: value stays low, only the enables move
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_o  <= 1'b0;
      int_o  <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      sda_o  <= 1'b0;
      int_o  <= 1'b0;
      int_oe <= |flag_q;
    end
  end
endmodule // gxp_core

// ==== dv/gxp_props.sv ====
// gxp_props.sv: port assertions for the gpio expander core
// assumes: bound onto gxp_core, link used as open drain
`timescale 1ns/1ns
module gxp_props (
  input wire        clk,
  input wire        nrst,
  input wire        scl_i,
  input wire        sda_o,
  input wire        sda_oe,
  input wire [15:0] gpio_i,
  input wire [15:0] gpio_o,
  input wire [15:0] gpio_oe,
  input wire [15:0] keep_en,
  input wire [15:0] pull_en,
  input wire [15:0] pull_up,
  input wire        int_o,
  input wire        int_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // pad values stay low, only the enables move
  a_pads_open_drain: assert property (!sda_o && !int_o)
    else $error("open drain value high");
  a_hold_pull_excl: assert property ((keep_en & pull_en) == 16'h0)
    else $error("keeper and pull both on");
  // register effects land while scl is low, after a data byte
  a_dir_scl_low: assert property (!$stable(gpio_oe) |-> !scl_i)
    else $error("direction moved with scl high");
  a_out_scl_low: assert property (!$stable(gpio_o) |-> !scl_i)
    else $error("output moved with scl high");
  a_cfg_scl_low: assert property
    (!$stable({keep_en, pull_en, pull_up}) |-> !scl_i)
    else $error("pin config moved with scl high");
  a_sda_scl_low: assert property (!$stable(sda_oe) |-> !scl_i)
    else $error("sda moved with scl high");
  // an interrupt needs a pin change within the last eight cycles
  a_int_has_cause: assert property
    ($rose(int_oe) |-> $past(gpio_i, 8) != gpio_i)
    else $error("interrupt without pin change");
  a_reset_quiet: assert property
    ($rose(nrst) |-> (gpio_oe | keep_en | pull_en) == 16'h0 && !int_oe)
    else $error("pins not idle after reset");
  c_int: cover property ($rose(int_oe));
  c_ack: cover property ($rose(sda_oe));
  c_out: cover property (!$stable(gpio_o));
endmodule // gxp_props

bind gxp_core gxp_props PROPS (.clk(clk), .nrst(nrst), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .gpio_i(gpio_i), .gpio_o(gpio_o),
  .gpio_oe(gpio_oe), .keep_en(keep_en), .pull_en(pull_en),
  .pull_up(pull_up), .int_o(int_o), .int_oe(int_oe));

// ==== dv/gxp_i2c_master.sv ====
// gxp_i2c_master.sv: behavioural serial bus master
// assumes: bench resolves sda with a pull-up
`timescale 1ns/1ns
module gxp_i2c_master (
  output logic scl,
  output logic sda_low,
  input  wire  sda
);
  // idle: lines released, clock stands high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // 125 ns bit slot, data moves only while scl is low
  task bt(input logic b, output logic s);
    sda_low = !b;
    #31 scl = 1'b1;
    #31 s = sda;
    #32 scl = 1'b0;
    #31;
  endtask
  // start or repeated start
  task start;
    sda_low = 1'b0;
    #31 scl = 1'b1;
    #31 sda_low = 1'b1;
    #31 scl = 1'b0;
    #32;
  endtask
  task stop;
    sda_low = 1'b1;
    #31 scl = 1'b1;
    #31 sda_low = 1'b0;
    #63;
  endtask
  // byte out msb first, ack sampled in ninth slot
  task sb(input logic [7:0] b, output logic ak);
    for (int k = 7; k >= 0; k--) bt(b[k], ak);
    bt(1'b1, ak);
  endtask
  task rb(input logic nack, output logic [7:0] b);
    logic s;
    for (int k = 7; k >= 0; k--) bt(1'b1, b[k]);
    bt(nack, s);
  endtask
endmodule // gxp_i2c_master

// ==== dv/gxp_core_bench.sv ====
// gxp_core_bench.sv: register level bench for the expander core
// assumes: gxp_defs.vh on the include path, checker bound
`timescale 1ns/1ns
`include "gxp_defs.vh"
module gxp_core_bench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] gpio_i = 16'hA35C;
  logic        scl, m_low, sda_o, sda_oe, int_o, int_oe, ak, w_oe;
  logic [15:0] gpio_o, gpio_oe, keep_en, pull_en, pull_up;
  logic [7:0]  m [16];
  logic [7:0]  rb;
  int          fails = 0;
  int          total_checks = 0;
  int          i;
  wire         sda = !(m_low | sda_oe | w_oe);
  always #4 clk = !clk;
  gxp_core DUT (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel_i(4'h0), .gpio_i(gpio_i),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .keep_en(keep_en),
    .pull_en(pull_en), .pull_up(pull_up), .int_o(int_o), .int_oe(int_oe));
  // wide variant on the same bus, address taken from its select pins
  gxp_core #(.WIDE_PKG(1)) DUT_WIDE (.clk(clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe(w_oe), .addr_sel_i(4'h5),
    .gpio_i(gpio_i), .gpio_o(), .gpio_oe(), .keep_en(), .pull_en(),
    .pull_up(), .int_o(), .int_oe());
  gxp_i2c_master MST (.scl(scl), .sda_low(m_low), .sda(sda));
  task stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // expected read value; inputs come live from the pins
  function logic [7:0] ex(input logic [3:0] p);
    ex = p == 0 ? gpio_i[7:0] ^ m[2] : p == 1 ? gpio_i[15:8] ^ m[3] : m[p];
  endfunction
  task hdr(input logic [7:0] c);
    MST.start;
    MST.sb({`GXP_FIXED_ADDR, 1'b0}, ak);
    chk(ak, 1'b0);
    MST.sb(c, ak);
    chk(ak, 1'b0);
  endtask
  // write n bytes, mirror skips read-only places
  task wr(input logic [7:0] c, b, input int n);
    logic [3:0] p;
    p = c[3:0];
    hdr(c);
    for (int k = 0; k < n; k++) begin
      MST.sb(b, ak);
      chk(ak, 1'b0);
      if (p > 1 && p < 14) m[p] = b;
      if (c[7]) p++;
      b += 8'h13;
    end
    MST.stop;
  endtask
  // read n bytes after repeated start, flags clear once read
  task rd(input logic [7:0] c, input int n);
    logic [3:0] p;
    p = c[3:0];
    hdr(c);
    MST.start;
    MST.sb({`GXP_FIXED_ADDR, 1'b1}, ak);
    chk(ak, 1'b0);
    for (int k = 0; k < n; k++) begin
      MST.rb(k == n - 1, rb);
      chk(rb, ex(p));
      if (p[3:1] == 3'h7) m[p] = 8'h00;
      if (c[7]) p++;
    end
    MST.stop;
  endtask
  task do_rst;
    @(negedge clk) nrst = 1'b0;
    repeat (4) @(negedge clk);
    chk(gpio_oe | keep_en | pull_en, 16'h0);
    nrst = 1'b1;
    for (int k = 2; k < 16; k++) m[k] = 8'h00;
    m[8] = `GXP_DIR_RST;
    m[9] = `GXP_DIR_RST;
    m[12] = `GXP_MSK_RST;
    m[13] = `GXP_MSK_RST;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    do_rst;
    MST.start;
    MST.sb({`GXP_FIXED_ADDR, 1'b1}, ak);
    MST.rb(1'b1, rb);
    MST.stop;
    chk(rb, ex(4'h0));
    rd(8'h82, 14);
    wr(8'h80, 8'h07, 18);
    chk(gpio_oe, ~{m[9], m[8]});
    chk(gpio_o, {m[11], m[10]});
    chk(keep_en, {{8{m[5][0]}}, {8{m[4][0]}}});
    chk(pull_en, {{8{m[5][1] & ~m[5][0]}}, {8{m[4][1] & ~m[4][0]}}});
    chk(pull_up, {m[7], m[6]});
    rd(8'h80, 17);
    wr(8'h0A, 8'h55, 2);
    rd(8'h0B, 2);
    hdr(8'h00);
    MST.sb(8'h00, ak);
    chk(ak, 1'b0);
    MST.start;
    MST.sb({`GXP_FIXED_ADDR, 1'b0}, ak);
    MST.sb(8'h1A, ak);
    chk(ak, 1'b1);
    MST.start;
    MST.sb({`GXP_FIXED_ADDR ^ 7'h01, 1'b0}, ak);
    chk(ak, 1'b1);
    MST.start;
    MST.sb({`GXP_ADDR_HI, 4'h5, 1'b0}, ak);
    chk(ak, 1'b0);
    MST.stop;
    // unmask one pin, toggle it, then a masked one
    wr(8'h0C, 8'hFE, 1);
    @(negedge clk) gpio_i[0] = !gpio_i[0];
    for (i = 0; i < 40 && int_oe !== 1'b1; i++) @(negedge clk);
    chk(int_oe, 1'b1);
    m[14] = 8'h01;
    rd(8'h0E, 2);
    chk(int_oe, 1'b0);
    @(negedge clk) gpio_i[1] = !gpio_i[1];
    repeat (20) @(negedge clk);
    chk(int_oe, 1'b0);
    do_rst;
    rd(8'h88, 6);
    stop_test;
  end
endmodule // gxp_core_bench
